// ===== core/pbsp_top.sv
// Pipelined burst static memory port: 32K words of 32 bits behind synchronous pins.
// Assumes the far end drives all synchronous pins from clk_sys and ties the strap.
//
// What this block does
// [R1] Store 32K words of four byte lanes.
// [R2] Input registers, output register, 2-bit burst counter.
// [R3] Capture inputs on rising edge, except three.
// [R4] Either start strobe loads external address.
// [R5] Step input advances burst in selected order.
// [R6] Static strap: low linear, high interleaved.
// [R7] Writes start on edge, finish self-timed.
// [R8] Qualifier with lane selects writes chosen lanes.
// [R9] Global write, or all selects, writes all lanes.
// [R10] Each lane select owns its own byte.
// [R11] Read data waits one extra edge in output register.
// [R12] Drive-on pin gates data drivers asynchronously.
// [R13] Controller start begins read, write or deselect.
// [R14] Processor start ignored while primary select high.
// [R15] Far end wires address LSBs to burst bits.
// [R16] All three selects true, else deselect.
// [R17] Sleep stops activity; low power until read or write.
// [R18] Far end disables drivers around write after read.
// [R19] Burst changes only low two bits, wrapping.
// [R20] No step, no strobe: address holds.
`timescale 1ns/10ps
`default_nettype none
module pbsp_top (
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              arst_n,
    // Address and burst control
    input  wire logic [pbsp_pkg::PBSP_UPPER_W-1:0] address_bus_in,
    input  wire logic [pbsp_pkg::PBSP_LOW_W-1:0]   burst_low_address_bits,
    input  wire logic                              processor_burst_start,
    input  wire logic                              controller_burst_start,
    input  wire logic                              burst_step,
    input  wire logic                              burst_order_select,
    // Chip selects
    input  wire logic                              primary_chip_select_n,
    input  wire logic                              expansion_select_high,
    input  wire logic                              expansion_select_low,
    // Write controls
    input  wire logic [pbsp_pkg::PBSP_LANES-1:0]   lane_write_select,
    input  wire logic                              byte_select_write_qualifier,
    input  wire logic                              all_lane_write,
    // Data pins
    input  wire logic [pbsp_pkg::PBSP_DATA_W-1:0]  data_lane_in,
    output logic [pbsp_pkg::PBSP_DATA_W-1:0]       data_lane_out,
    output logic                                   data_lane_oe_n,
    // Asynchronous controls
    input  wire logic                              output_drive_on,
    input  wire logic                              sleep_request,
    // Status
    output logic                                   low_power,
    output logic                                   write_ready
);
    import pbsp_pkg::*;

    // =====================================================================
    // Input registers and sleep synchroniser
    // =====================================================================
    pbsp_in_t    in_q, next_in;
    logic        sleep_meta, sleep_s;

    always_comb begin
        next_in.upper    = address_bus_in;
        next_in.low      = burst_low_address_bits;
        next_in.pbs      = processor_burst_start;
        next_in.cbs      = controller_burst_start;
        next_in.step     = burst_step;
        next_in.cs1_n    = primary_chip_select_n;
        next_in.cs2      = expansion_select_high;
        next_in.cs3_n    = expansion_select_low;
        next_in.lane_sel = lane_write_select;
        next_in.qual     = byte_select_write_qualifier;
        next_in.all_wr   = all_lane_write;
        next_in.data     = data_lane_in;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_q       <= '0;
            sleep_meta <= 1'b0;
            sleep_s    <= 1'b0;
        end else begin
            in_q       <= next_in; // [R2] [R3]
            sleep_meta <= sleep_request;
            sleep_s    <= sleep_meta;
        end
    end

    // =====================================================================
    // Cycle decode and burst counter
    // =====================================================================
    pbsp_state_t            state, next_state;
    logic [PBSP_UPPER_W-1:0] upper, next_upper;
    logic [PBSP_LOW_W-1:0]   base, next_base, cnt, next_cnt, acc_low;
    logic [PBSP_ADDR_W-1:0]  acc_addr;
    logic [PBSP_LANES-1:0]   wr_mask;
    logic                    sel_ok, wr_any, start, desel, cont, do_rd, do_wr;
    logic                    next_low_power;

    assign sel_ok = !in_q.cs1_n && in_q.cs2 && !in_q.cs3_n; // [R16]
    assign wr_any = in_q.all_wr || (in_q.qual && (in_q.lane_sel != PBSP_NO_LANES));

    always_comb begin
        if (in_q.all_wr) begin
            wr_mask = PBSP_ALL_LANES; // [R9]
        end else if (in_q.qual) begin
            wr_mask = in_q.lane_sel; // [R8] [R9]
        end else begin
            wr_mask = PBSP_NO_LANES;
        end
    end

    always_comb begin
        next_state = state;
        next_upper = upper;
        next_base  = base;
        next_cnt   = cnt;
        start      = 1'b0;
        desel      = 1'b0;
        cont       = 1'b0;
        do_rd      = 1'b0;
        do_wr      = 1'b0;
        if (sleep_s) begin
            // Internal clock is considered stopped: no command is taken.
            next_state = state; // [R17]
        end else if (in_q.pbs && !in_q.cs1_n) begin
            // A processor start with all three selects true always begins with a read; with the primary select low and another select false it deselects.
            if (sel_ok) begin
                start = 1'b1; // [R4] [R14]
                do_rd = 1'b1;
            end else begin
                desel = 1'b1; // [R14] [R16]
            end
        end else if (in_q.cbs) begin
            if (sel_ok) begin
                start = 1'b1; // [R4] [R13]
                do_wr = wr_any;
                do_rd = !wr_any;
            end else begin
                desel = 1'b1; // [R13] [R16]
            end
        end else if (state == PBSP_BURST) begin
            cont  = 1'b1;
            do_wr = wr_any;
            do_rd = !wr_any;
            if (in_q.step) begin
                next_cnt = cnt + PBSP_CNT_STEP; // [R5] [R19]
            end
        end
        if (start) begin
            next_state = PBSP_BURST;
            next_upper = in_q.upper; // [R4]
            next_base  = in_q.low;
            next_cnt   = PBSP_CNT_RST;
        end
        if (desel) begin
            next_state = PBSP_DESEL;
        end
    end

    // The strap is used live, never registered.
    always_comb begin
        if (burst_order_select) begin
            acc_low = next_base ^ next_cnt; // [R6]
        end else begin
            acc_low = next_base + next_cnt; // [R6] [R19]
        end
    end

    assign acc_addr = {next_upper, acc_low}; // [R19] [R20]

    always_comb begin
        next_low_power = low_power;
        if (sleep_s) begin
            next_low_power = 1'b1; // [R17]
        end else if (do_rd || do_wr) begin
            next_low_power = 1'b0; // [R17]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state     <= PBSP_DESEL;
            upper     <= '0;
            base      <= PBSP_CNT_RST;
            cnt       <= PBSP_CNT_RST;
            low_power <= 1'b0;
        end else begin
            state     <= next_state;
            upper     <= next_upper;
            base      <= next_base;
            cnt       <= next_cnt;
            low_power <= next_low_power;
        end
    end

    // =====================================================================
    // Write buffer and storage array
    // =====================================================================
    pbsp_wr_t wr_cmd, head;
    logic     fifo_in_ready, head_valid, drain;

    assign wr_cmd.addr = acc_addr;
    assign wr_cmd.data = in_q.data;
    assign wr_cmd.mask = wr_mask;

    // Draining stalls while asleep, so queued writes survive sleep intact.
    assign drain = head_valid && !sleep_s; // [R7] [R17]

    pbsp_fifo #(
        .WIDTH (PBSP_WR_W),
        .DEPTH (PBSP_FIFO_D)
    ) u_wr_fifo (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .in_valid  (do_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_cmd),
        .out_valid (head_valid),
        .out_ready (!sleep_s),
        .out_data  (head)
    );

    logic [PBSP_DATA_W-1:0] rd_word;

    // The head write lands on the same edge as a read; forward its lanes.
    for (genvar g = 0; g < PBSP_LANES; g++) begin : g_lane
        logic [PBSP_LANE_W-1:0] lane_mem [PBSP_WORDS]; // [R1]
        logic                   fwd;

        assign fwd = head_valid && head.mask[g] && (head.addr == acc_addr);
        assign rd_word[g*PBSP_LANE_W +: PBSP_LANE_W] =
            fwd ? head.data[g*PBSP_LANE_W +: PBSP_LANE_W] : lane_mem[acc_addr];

        always_ff @(posedge clk_sys) begin
            if (drain && head.mask[g]) begin
                lane_mem[head.addr] <= head.data[g*PBSP_LANE_W +: PBSP_LANE_W]; // [R7] [R10]
            end
        end
    end

    // =====================================================================
    // Read pipeline and output stage
    // =====================================================================
    logic [PBSP_DATA_W-1:0] rd_q;
    logic                   rd_valid, drive;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_q          <= '0;
            rd_valid      <= 1'b0;
            data_lane_out <= '0;
            drive         <= 1'b0;
            write_ready   <= 1'b0;
        end else begin
            rd_q          <= rd_word;
            rd_valid      <= do_rd;
            data_lane_out <= rd_q; // [R11]
            drive         <= rd_valid; // [R11]
            write_ready   <= fifo_in_ready;
        end
    end

    // Enable must follow the drive-on and sleep pins without a clock edge.
    assign data_lane_oe_n = !drive || output_drive_on || sleep_request; // [R12] [R18]

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    property p_start_load;
        start |=> (cnt == PBSP_CNT_RST) && (base == $past(in_q.low))
                  && (upper == $past(in_q.upper));
    endproperty
    a_start_load: assert property (p_start_load) // [R4]
        else $error("Burst start did not load the external address.");

    property p_step;
        cont && in_q.step |=> cnt == $past(cnt) + PBSP_CNT_STEP;
    endproperty
    a_step: assert property (p_step) // [R5]
        else $error("Step did not advance the burst counter.");

    property p_hold;
        cont && !in_q.step |=> $stable(cnt) && $stable(base) && (state == PBSP_BURST);
    endproperty
    a_hold: assert property (p_hold) // [R20]
        else $error("Burst address moved without a step.");

    property p_upper;
        cont |=> $stable(upper);
    endproperty
    a_upper: assert property (p_upper) // [R19]
        else $error("Upper address changed inside a burst.");

    property p_order;
        cont && (state == PBSP_BURST) |->
            acc_addr[1:0] == (burst_order_select ? (base ^ next_cnt) : (base + next_cnt));
    endproperty
    a_order: assert property (p_order) // [R6]
        else $error("Burst address does not follow the selected order.");

    property p_pipe;
        do_rd |-> ##2 drive && (data_lane_out == $past(rd_q));
    endproperty
    a_pipe: assert property (p_pipe) // [R11]
        else $error("Read data did not pass the output register.");

    property p_lanes;
        do_wr && !in_q.all_wr |-> wr_cmd.mask == in_q.lane_sel;
    endproperty
    a_lanes: assert property (p_lanes) // [R8]
        else $error("Byte write mask differs from the lane selects.");

    property p_global;
        do_wr && (in_q.all_wr || (in_q.qual && in_q.lane_sel == PBSP_ALL_LANES))
            |-> wr_cmd.mask == PBSP_ALL_LANES;
    endproperty
    a_global: assert property (p_global) // [R9]
        else $error("Global write did not select every lane.");

    property p_desel;
        in_q.cbs && !in_q.pbs && !sel_ok && !sleep_s |=> state == PBSP_DESEL;
    endproperty
    a_desel: assert property (p_desel) // [R13]
        else $error("Controller start with a false select did not deselect.");

    property p_proc_block;
        in_q.pbs && in_q.cs1_n && !in_q.cbs && !sleep_s && state == PBSP_BURST
            |=> state == PBSP_BURST;
    endproperty
    a_proc_block: assert property (p_proc_block) // [R14]
        else $error("Processor start with primary select high deselected.");

    property p_sleep;
        sleep_s |-> !do_rd && !do_wr && !drain ##1 low_power;
    endproperty
    a_sleep: assert property (p_sleep) // [R17]
        else $error("Activity seen while asleep.");

    property p_drive_off;
        output_drive_on || sleep_request |-> data_lane_oe_n;
    endproperty
    a_drive_off: assert property (p_drive_off) // [R12]
        else $error("Data drivers on while drive-on is high.");
endmodule : pbsp_top
`default_nettype wire

// ===== core/pbsp_pkg.sv
// Shared widths, reset values and carrier types of the pipelined burst memory port.
// Assumes one clock domain; every user includes it by package import.
package pbsp_pkg;
    localparam int PBSP_DATA_W   = 32;
    localparam int PBSP_LANES    = 4;
    localparam int PBSP_LANE_W   = 8;
    localparam int PBSP_ADDR_W   = 15;
    localparam int PBSP_LOW_W    = 2;
    localparam int PBSP_UPPER_W  = 13;
    localparam int PBSP_WORDS    = 32768;
    localparam int PBSP_FIFO_D   = 4;
    localparam logic [1:0] PBSP_CNT_RST   = 2'h0;
    localparam logic [1:0] PBSP_CNT_STEP  = 2'h1;
    localparam logic [3:0] PBSP_ALL_LANES = 4'hf;
    localparam logic [3:0] PBSP_NO_LANES  = 4'h0;

    typedef enum logic {PBSP_DESEL, PBSP_BURST} pbsp_state_t;

    // Everything the input registers capture on one clock edge.
    typedef struct packed {
        logic [PBSP_UPPER_W-1:0] upper;
        logic [PBSP_LOW_W-1:0]   low;
        logic                    pbs;
        logic                    cbs;
        logic                    step;
        logic                    cs1_n;
        logic                    cs2;
        logic                    cs3_n;
        logic [PBSP_LANES-1:0]   lane_sel;
        logic                    qual;
        logic                    all_wr;
        logic [PBSP_DATA_W-1:0]  data;
    } pbsp_in_t;

    // One queued write: word address, data and lane mask.
    typedef struct packed {
        logic [PBSP_ADDR_W-1:0] addr;
        logic [PBSP_DATA_W-1:0] data;
        logic [PBSP_LANES-1:0]  mask;
    } pbsp_wr_t;

    localparam int PBSP_WR_W = $bits(pbsp_wr_t);
endpackage : pbsp_pkg

// ===== core/pbsp_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two of at least 2.
`timescale 1ns/10ps
`default_nettype none
module pbsp_fifo #(
    parameter int WIDTH = 51,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slot [DEPTH];
    logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             push, pop;

    assign in_ready  = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data  = slot[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr + AW'(push);
        next_rd_ptr = rd_ptr + AW'(pop);
        next_count  = count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end
endmodule : pbsp_fifo
`default_nettype wire

// ===== verif/pbsp_host_model.sv
// Cache-controller model that drives burst cycles into the memory port.
// Assumes the bench calls its tasks; each task waits for one rising edge.
`timescale 1ns/10ps
`default_nettype none
module pbsp_host_model (
    // Clock
    input  wire logic              clk_sys,
    // Synchronous pins toward the memory port
    output var pbsp_pkg::pbsp_in_t pins,
    // Strap and asynchronous controls
    output logic                   order_strap,
    output logic                   drive_off,
    output logic                   sleep_req
);
    import pbsp_pkg::*;

    logic [PBSP_DATA_W-1:0] last_data;

    initial begin
        pins = '{cs1_n: 1'b1, cs3_n: 1'b1, default: '0};
        order_strap = 1'b0;
        drive_off = 1'b1;
        sleep_req = 1'b0;
        last_data = '0;
    end

    // ==========================================================
    // Cycle drivers
    // Write cycles turn the data drivers off before they are taken.
    task automatic send(input pbsp_in_t c, input logic hold_off);
        @(posedge clk_sys);
        pins <= c;
        last_data <= c.data;
        drive_off <= hold_off | c.all_wr | (c.qual & |c.lane_sel);
    endtask : send

    // Idle cycles deselect through a controller start with the primary select high,
    // so a burst never runs on into them; idle pins invert the previous cycle's address and the last sent data.
    task automatic rest(input logic hold_off);
        @(posedge clk_sys);
        pins <= '{upper: ~pins.upper, low: ~pins.low, cbs: 1'b1, cs1_n: 1'b1, cs3_n: 1'b1,
                  data: ~last_data, default: '0};
        drive_off <= hold_off;
    endtask : rest

    // The strap only changes while the port is idle.
    task automatic set_strap(input logic ord);
        @(posedge clk_sys);
        order_strap <= ord;
    endtask : set_strap

    task automatic set_sleep(input logic v);
        @(posedge clk_sys);
        sleep_req <= v;
    endtask : set_sleep
endmodule : pbsp_host_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the pipelined burst memory port.
// Assumes the host model drives every synchronous pin and the strap.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pbsp_pkg::*;

    logic                   clk_sys = 1'b0;
    logic                   arst_n = 1'b0;
    pbsp_in_t               pins;
    logic                   order_strap;
    logic                   drive_off;
    logic                   sleep_req;
    logic [PBSP_DATA_W-1:0] data_lane_out;
    logic                   data_lane_oe_n;
    logic                   low_power;
    logic                   write_ready;
    int                     num_errors = 0;
    int                     cmp_count = 0;
    logic [PBSP_DATA_W-1:0] ref_mem [logic [PBSP_ADDR_W-1:0]];

    always #12.5 clk_sys = ~clk_sys;

    pbsp_host_model i_pbsp_host_model (.clk_sys(clk_sys), .pins(pins),
        .order_strap(order_strap), .drive_off(drive_off), .sleep_req(sleep_req));

    pbsp_top i_pbsp_top (.clk_sys(clk_sys), .arst_n(arst_n), .address_bus_in(pins.upper),
        .burst_low_address_bits(pins.low), .processor_burst_start(pins.pbs),
        .controller_burst_start(pins.cbs), .burst_step(pins.step),
        .burst_order_select(order_strap), .primary_chip_select_n(pins.cs1_n),
        .expansion_select_high(pins.cs2), .expansion_select_low(pins.cs3_n),
        .lane_write_select(pins.lane_sel), .byte_select_write_qualifier(pins.qual),
        .all_lane_write(pins.all_wr), .data_lane_in(pins.data),
        .data_lane_out(data_lane_out), .data_lane_oe_n(data_lane_oe_n),
        .output_drive_on(drive_off), .sleep_request(sleep_req), .low_power(low_power),
        .write_ready(write_ready));

    // ==========================================================
    // Helpers
    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk1

    function automatic pbsp_in_t mk(input logic [14:0] a, input logic pbs, input logic cbs,
        input logic step, input logic [3:0] lanes, input logic qual, input logic all_wr,
        input logic [31:0] d);
        return '{upper: a[14:2], low: a[1:0], pbs: pbs, cbs: cbs, step: step, cs1_n: 1'b0,
                 cs2: 1'b1, cs3_n: 1'b0, lane_sel: lanes, qual: qual, all_wr: all_wr, data: d};
    endfunction : mk

    function automatic logic [14:0] baddr(input logic [14:0] a, input int idx, input logic ord);
        logic [1:0] n;
        n = idx[1:0];
        return {a[14:2], ord ? (a[1:0] ^ n) : (a[1:0] + n)};
    endfunction : baddr

    // ==========================================================
    // Scenarios
    // Four-beat write burst; the reference array keeps only the enabled lanes.
    task automatic wr_burst(input logic [14:0] a, input logic [3:0] lanes, input logic qual,
        input logic all_wr, input logic [31:0] seed);
        pbsp_in_t    c;
        logic [31:0] d;
        logic [14:0] wa;
        for (int i = 0; i < 4; i++) begin
            d = seed + i * 32'h01010101;
            c = mk(a, 1'b0, i == 0, i != 0, lanes, qual, all_wr, d);
            i_pbsp_host_model.send(c, 1'b0);
            wa = baddr(a, i, order_strap);
            if (!ref_mem.exists(wa)) ref_mem[wa] = '0;
            for (int l = 0; l < PBSP_LANES; l++) begin
                if (all_wr || (qual && lanes[l])) ref_mem[wa][l*8 +: 8] = d[l*8 +: 8];
            end
        end
        repeat (3) i_pbsp_host_model.rest(1'b1);
    endtask : wr_burst

    // Read burst: stp gives the step of beats 1 to 3, ign adds an ignored start on
    // beat 2, off turns the drivers off per cycle.
    task automatic rd_burst(input logic [14:0] a, input logic [3:0] stp, input logic ign,
        input logic [7:0] off);
        pbsp_in_t    c;
        int          idx;
        logic [14:0] exp_a [4];
        idx = 0;
        for (int k = 0; k < 8; k++) begin
            if (k < 4) begin
                if (k > 0 && stp[k]) idx++;
                exp_a[k] = baddr(a, idx, order_strap);
                c = mk(a, k == 0, 1'b0, k > 0 && stp[k], 4'h0, 1'b0, 1'b0, 32'h5a5a5a5a);
                if (ign && k == 2) begin
                    c.pbs = 1'b1;
                    c.cs1_n = 1'b1;
                    c.upper = ~c.upper;
                end
                i_pbsp_host_model.send(c, off[k]);
            end else begin
                i_pbsp_host_model.rest(off[k]);
            end
            @(negedge clk_sys);
            if (k == 2 || k == 7) chk1(data_lane_oe_n, 1'b1, "drive outside slot");
            if (k >= 3 && k <= 6) begin
                chk32(data_lane_out, ref_mem[exp_a[k-3]], "read data");
                chk1(data_lane_oe_n, off[k], "drive in slot");
            end
        end
    endtask : rd_burst

    // Deselect cases end a running burst; a following continue must neither write nor drive.
    task automatic s_desel(input logic [14:0] a);
        pbsp_in_t c;
        for (int v = 0; v < 3; v++) begin
            i_pbsp_host_model.send(mk(a, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, ref_mem[a]), 1'b0);
            c = mk(a, v != 2, v == 2, 1'b0, 4'h0, 1'b0, 1'b0, 32'h0);
            if (v == 0) c.cs2 = 1'b0;
            if (v == 1) c.cs3_n = 1'b1;
            if (v == 2) c.cs1_n = 1'b1;
            i_pbsp_host_model.send(c, 1'b0);
            i_pbsp_host_model.send(mk(a, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0, 1'b1, 32'hffffffff), 1'b0);
            for (int k = 0; k < 4; k++) begin
                if (k == 0) i_pbsp_host_model.send(mk(a, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, 32'h0), 1'b0);
                else i_pbsp_host_model.rest(1'b0);
                @(negedge clk_sys);
                chk1(data_lane_oe_n, 1'b1, "deselected drive");
            end
            rd_burst(a, 4'he, 1'b0, 8'h00);
        end
    endtask : s_desel

    // Sleep drops commands, keeps data and stays low power until a read or write.
    task automatic s_sleep(input logic [14:0] a);
        int n;
        i_pbsp_host_model.set_sleep(1'b1);
        n = 0;
        while (low_power !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        chk1(low_power, 1'b1, "sleep entry");
        if (n == 8) end_sim();
        i_pbsp_host_model.send(mk(a, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1, 32'h0), 1'b0);
        i_pbsp_host_model.rest(1'b1);
        i_pbsp_host_model.set_sleep(1'b0);
        repeat (6) i_pbsp_host_model.rest(1'b0);
        @(negedge clk_sys);
        chk1(low_power, 1'b1, "low power after wake");
        rd_burst(a, 4'he, 1'b0, 8'h00);
        chk1(low_power, 1'b0, "low power after read");
    endtask : s_sleep

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk32(data_lane_out, 32'h0, "reset data");
        chk1(data_lane_oe_n, 1'b1, "reset drive");
        chk1(low_power, 1'b0, "reset low power");
        chk1(write_ready, 1'b0, "reset write ready");
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk1(write_ready, 1'b1, "write ready after reset");
        i_pbsp_host_model.set_strap(1'b0);
        wr_burst(15'h1236, 4'h0, 1'b0, 1'b1, 32'h11223344);
        rd_burst(15'h1236, 4'he, 1'b0, 8'h00);
        rd_burst(15'h1236, 4'ha, 1'b1, 8'h20);
        i_pbsp_host_model.set_strap(1'b1);
        wr_burst(15'h2a51, 4'h0, 1'b0, 1'b1, 32'ha0b0c0d0);
        rd_burst(15'h2a51, 4'he, 1'b0, 8'h00);
        for (int l = 0; l < 4; l++) begin
            wr_burst(15'h2a51, 4'h1 << l, 1'b1, 1'b0, 32'h0f0f0f0f * (l + 1));
        end
        wr_burst(15'h2a56, 4'hf, 1'b1, 1'b0, 32'h76543210);
        rd_burst(15'h2a51, 4'he, 1'b0, 8'h00);
        rd_burst(15'h2a56, 4'he, 1'b0, 8'h00);
        s_desel(15'h1236);
        s_sleep(15'h2a51);
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        $display("CHECK FAILED t=%0t run limit reached", $time);
        end_sim();
    end
endmodule : tb
`default_nettype wire
